// *** logic/wro_pkg.sv ***
// constants, states and bundles of the serial watch control block
// assumes a single 125 MHz clock domain; the host pins are asynchronous to it
package wro_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_PERIOD_NS = 10_000_000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PTR_W = 6;
   localparam int REG_HUND = 0;
   localparam int REG_SEC = 1;
   localparam int REG_MIN = 2;
   localparam int REG_HOUR = 3;
   localparam int REG_DAY = 4;
   localparam int RST_CTRL_BIT = 4;
   localparam int OSC_CTRL_BIT = 5;
   localparam logic [63:0] MATCH_PATTERN = 64'h5CA3_3AC5_5CA3_3AC5;
   // one byte per register, register 0 in the low byte
   localparam logic [7:0][7:0] VALID_MASK = 64'hFF1F_3F37_BF7F_7FFF;
   localparam logic [7:0][7:0] REGS_RESET = 64'h0000_0031_0000_0000;
   localparam logic [7:0] HUND_TOP = 8'h99;
   localparam logic [7:0] SEC_TOP = 8'h59;
   localparam logic [7:0] HOUR_TOP = 8'h23;
   localparam logic [2:0] DAY_FIRST = 3'h1;
   localparam logic [2:0] DAY_LAST = 3'h7;
   localparam logic [5:0] PTR_LAST = 6'h3F;

   typedef enum logic [1:0] {
      WRO_IDLE = 2'b00,
      WRO_MATCH = 2'b01,
      WRO_XFER = 2'b11
   } wro_state_type;

   typedef struct packed {
      logic is_write;
      logic data;
   } wro_evt_type;

   typedef struct packed {
      logic rst_n;
      logic din;
      logic we_n;
      logic oe_n;
      logic ce_n;
   } wro_pins_type;

   localparam logic [4:0] PINS_IDLE = 5'h1F;
endpackage

// *** logic/wro_sync.sv ***
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes the inputs idle at the reset value
`timescale 1ns/1ps
`default_nettype none
module wro_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] INIT = '1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   // pins in, filtered level out
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } sync_state_type;

   sync_state_type st_reg;
   sync_state_type st_next;

   // the first stage feeds only the second
   always_comb begin
      st_next = st_reg;
      st_next.s1 = async_i;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.level[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= {INIT, INIT, INIT, INIT};
      end else if (en_i) begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.level;
endmodule
`default_nettype wire

// *** logic/wro_buf.sv ***
// two-entry buffer with valid/ready on both sides
// assumes one clock; a push into a full buffer is refused via in_ready_o
`timescale 1ns/1ps
`default_nettype none
module wro_buf #(
   parameter int W = 2
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   // filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   typedef struct packed {
      logic [1:0][W-1:0] slot;
      logic [1:0] count;
   } buf_state_type;

   buf_state_type st_reg;
   buf_state_type st_next;
   logic push;
   logic pop;

   always_comb begin
      st_next = st_reg;
      push = in_valid_i && (st_reg.count != 2'd2);
      pop = out_ready_i && (st_reg.count != 2'd0);
      if (pop) begin
         st_next.slot[0] = st_reg.slot[1];
      end
      if (push) begin
         st_next.slot[(st_reg.count - 2'(pop)) == 2'd0 ? 0 : 1] = in_data_i;
      end
      st_next.count = st_reg.count + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else if (en_i) begin
         st_reg <= st_next;
      end
   end

   assign in_ready_o = (st_reg.count != 2'd2);
   assign out_valid_o = (st_reg.count != 2'd0);
   assign out_data_o = st_reg.slot[0];
endmodule
`default_nettype wire

// *** logic/wro_core.sv ***
// serial watch control: pattern match, 64-bit transfer, reset and oscillator bits
// assumes asynchronous host strobes slower than about 10 clocks per cycle
// Functional notes
// - day bits 4 and 5 are controls
// - reset bit 1 ignores reset pin
// - reset bit 0, low pin aborts transfer
// - oscillator bit 1 stops time counting
// - oscillator bit 0 runs time counting
// - both control bits reset to 1
// - unused register bits read as 0
// - writes to unused bits have no effect
// - read during matching restarts the pointer
// - after match 64 cycles move bits
// - bit order register 0 bit 0 first
`timescale 1ns/1ps
`default_nettype none
module wro_core #(
   parameter int TICK_CYCLES = wro_pkg::TICK_CYCLES
) (
   // clock, reset, clock enable
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   // host strobes and reset pin, all active low
   input wire logic ce_pin_n_i,
   input wire logic oe_pin_n_i,
   input wire logic we_pin_n_i,
   input wire logic rst_pin_n_i,
   // two-way serial data line
   input wire logic serial_bit_line_i,
   output logic serial_bit_line_o,
   output logic serial_bit_line_oe_o,
   // memory side and status
   output logic mem_inhibit_o,
   output logic osc_running_o,
   output logic [7:0] hundredths_o
);
   localparam int CW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      wro_pkg::wro_state_type state;
      logic [wro_pkg::PTR_W-1:0] ptr;
      logic [7:0][7:0] regs;
      logic [CW-1:0] tick_cnt;
      logic ce_prev;
      logic lat_we;
      logic lat_oe;
      logic lat_bit;
      logic out_bit;
      logic drive;
   } core_state_type;

   core_state_type st_reg;
   core_state_type st_next;
   wro_pkg::wro_pins_type pins;
   wro_pkg::wro_evt_type evt_in;
   wro_pkg::wro_evt_type evt_out;
   logic evt_push;
   logic buf_in_ready;
   logic evt_valid;
   logic eng_ready;
   logic tick_now;
   logic abort;
   logic [8:0] hund_inc;
   logic [8:0] sec_inc;
   logic [8:0] min_inc;
   logic [8:0] hour_inc;

   // bcd increment, result is {carry, value}; value wraps to zero past top
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
      if (v >= top) begin
         bcd_inc = 9'h000;
         bcd_inc[8] = 1'b1;
      end else if (v[3:0] >= 4'h9) begin
         bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // which bits of a register exist
   function automatic logic bit_valid(input logic [wro_pkg::PTR_W-1:0] p);
      bit_valid = wro_pkg::VALID_MASK[p[5:3]][p[2:0]];
   endfunction

   wro_sync #(
      .W($bits(wro_pkg::wro_pins_type)),
      .INIT(wro_pkg::PINS_IDLE)
   ) u_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .en_i(en_i),
      .async_i({rst_pin_n_i, serial_bit_line_i, we_pin_n_i, oe_pin_n_i, ce_pin_n_i}),
      .level_o(pins)
   );

   // host cycles queue here so the one-cycle stall for a time update loses nothing
   wro_buf #(
      .W($bits(wro_pkg::wro_evt_type))
   ) u_buf (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .en_i(en_i),
      .in_valid_i(evt_push),
      .in_ready_o(buf_in_ready),
      .in_data_i(evt_in),
      .out_valid_o(evt_valid),
      .out_ready_i(eng_ready),
      .out_data_o(evt_out)
   );

   always_comb begin
      st_next = st_reg;
      evt_in = '0;
      evt_push = 1'b0;
      abort = 1'b0;
      tick_now = 1'b0;
      hund_inc = bcd_inc(st_reg.regs[wro_pkg::REG_HUND], wro_pkg::HUND_TOP);
      sec_inc = bcd_inc(st_reg.regs[wro_pkg::REG_SEC], wro_pkg::SEC_TOP);
      min_inc = bcd_inc(st_reg.regs[wro_pkg::REG_MIN], wro_pkg::SEC_TOP);
      hour_inc = bcd_inc({2'b00, st_reg.regs[wro_pkg::REG_HOUR][5:0]}, wro_pkg::HOUR_TOP);

      // strobe levels are caught while the chip enable is low, used at its rise
      st_next.ce_prev = pins.ce_n;
      if (!pins.ce_n) begin
         st_next.lat_we = ~pins.we_n;
         st_next.lat_oe = ~pins.oe_n;
         st_next.lat_bit = pins.din;
      end
      if (pins.ce_n && !st_reg.ce_prev && (st_reg.lat_we || st_reg.lat_oe)) begin
         evt_in.is_write = st_reg.lat_we;
         evt_in.data = st_reg.lat_bit;
         evt_push = buf_in_ready;
      end

      // control bits live in the day register
      if (!st_reg.regs[wro_pkg::REG_DAY][wro_pkg::RST_CTRL_BIT]) begin
         abort = ~pins.rst_n;
      end

      // time base only runs while the oscillator bit is clear
      if (!st_reg.regs[wro_pkg::REG_DAY][wro_pkg::OSC_CTRL_BIT]) begin
         if (st_reg.tick_cnt == CW'(TICK_CYCLES - 1)) begin
            st_next.tick_cnt = '0;
            tick_now = 1'b1;
         end else begin
            st_next.tick_cnt = st_reg.tick_cnt + CW'(1);
         end
      end
      // date, month and year are kept by software; only the day of week rolls
      if (tick_now) begin
         st_next.regs[wro_pkg::REG_HUND] = hund_inc[7:0];
         if (hund_inc[8]) begin
            st_next.regs[wro_pkg::REG_SEC] = sec_inc[7:0];
            if (sec_inc[8]) begin
               st_next.regs[wro_pkg::REG_MIN] = min_inc[7:0];
               if (min_inc[8]) begin
                  st_next.regs[wro_pkg::REG_HOUR][5:0] = hour_inc[5:0];
                  if (hour_inc[8]) begin
                     if (st_reg.regs[wro_pkg::REG_DAY][2:0] == wro_pkg::DAY_LAST) begin
                        st_next.regs[wro_pkg::REG_DAY][2:0] = wro_pkg::DAY_FIRST;
                     end else begin
                        st_next.regs[wro_pkg::REG_DAY][2:0] =
                           st_reg.regs[wro_pkg::REG_DAY][2:0] + 3'h1;
                     end
                  end
               end
            end
         end
      end

      // the engine waits out the update cycle so both never write a register at once
      eng_ready = ~tick_now;

      if (abort) begin
         // register contents stay as they are
         st_next.state = wro_pkg::WRO_IDLE;
         st_next.ptr = '0;
      end else if (evt_valid && eng_ready) begin
         case (st_reg.state)
            wro_pkg::WRO_IDLE: begin
               if (!evt_out.is_write) begin
                  st_next.state = wro_pkg::WRO_MATCH;
                  st_next.ptr = '0;
               end
            end
            wro_pkg::WRO_MATCH: begin
               if (!evt_out.is_write) begin
                  st_next.ptr = '0;
               end else if (evt_out.data == wro_pkg::MATCH_PATTERN[st_reg.ptr]) begin
                  st_next.ptr = st_reg.ptr + 6'h01;
                  if (st_reg.ptr == wro_pkg::PTR_LAST) begin
                     st_next.state = wro_pkg::WRO_XFER;
                  end
               end else begin
                  // a miss parks the pointer; later writes are ignored until a read
                  st_next.state = wro_pkg::WRO_IDLE;
                  st_next.ptr = '0;
               end
            end
            wro_pkg::WRO_XFER: begin
               if (evt_out.is_write && bit_valid(st_reg.ptr)) begin
                  st_next.regs[st_reg.ptr[5:3]][st_reg.ptr[2:0]] = evt_out.data;
               end
               st_next.ptr = st_reg.ptr + 6'h01;
               if (st_reg.ptr == wro_pkg::PTR_LAST) begin
                  st_next.state = wro_pkg::WRO_IDLE;
               end
            end
            default: begin
               st_next.state = wro_pkg::WRO_IDLE;
               st_next.ptr = '0;
            end
         endcase
      end

      // read data: missing bits always read zero
      // the bit is frozen while driven, so a time update mid-read cannot change it
      if (st_reg.drive) begin
         st_next.out_bit = st_reg.out_bit;
      end else begin
         st_next.out_bit = st_reg.regs[st_reg.ptr[5:3]][st_reg.ptr[2:0]] & bit_valid(st_reg.ptr);
      end
      st_next.drive = (st_reg.state == wro_pkg::WRO_XFER) && !abort && !pins.ce_n
         && !pins.oe_n && pins.we_n;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
         st_reg.state <= wro_pkg::WRO_IDLE;
         st_reg.regs <= wro_pkg::REGS_RESET;
         st_reg.ce_prev <= 1'b1;
      end else if (en_i) begin
         st_reg <= st_next;
      end
   end

   assign serial_bit_line_o = st_reg.out_bit;
   assign serial_bit_line_oe_o = st_reg.drive;
   // memory sees the cycle unless a watch transfer owns it
   assign mem_inhibit_o = (st_reg.state == wro_pkg::WRO_XFER);
   assign osc_running_o = ~st_reg.regs[wro_pkg::REG_DAY][wro_pkg::OSC_CTRL_BIT];
   assign hundredths_o = st_reg.regs[wro_pkg::REG_HUND];
endmodule
`default_nettype wire

// *** testbench/wro_core_checker.sv ***
// concurrent checks on the serial watch control's ports
// assumes it is bound to every wro_core instance by the line at the foot
`timescale 1ns/1ps
`default_nettype none
module wro_core_checker #(
   parameter int TICK_CYCLES = 1000
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   // host pins
   input wire logic ce_pin_n_i,
   input wire logic oe_pin_n_i,
   input wire logic we_pin_n_i,
   input wire logic rst_pin_n_i,
   input wire logic serial_bit_line_i,
   // core outputs
   input wire logic serial_bit_line_o,
   input wire logic serial_bit_line_oe_o,
   input wire logic mem_inhibit_o,
   input wire logic osc_running_o,
   input wire logic [7:0] hundredths_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   int idle_cnt;
   // only an upper bound: a write to hundredths restarts this count but not the tick
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         idle_cnt <= 0;
      end else if (!osc_running_o || $changed(hundredths_o)) begin
         idle_cnt <= 0;
      end else begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   sequence ce_release;
      $rose(ce_pin_n_i);
   endsequence
   sequence driving_on;
      serial_bit_line_oe_o ##1 serial_bit_line_oe_o;
   endsequence
   reset_vals_a: assert property ($rose(nrst_i) |-> !osc_running_o && !mem_inhibit_o)
      else $error("outputs wrong after reset release");
   osc_stop_a: assert property (!osc_running_o && !mem_inhibit_o |=> $stable(hundredths_o))
      else $error("hundredths moved while oscillator off");
   osc_tick_a: assert property ($changed(hundredths_o) |-> $past(osc_running_o) || $past(mem_inhibit_o))
      else $error("hundredths changed without cause");
   tick_bound_a: assert property (idle_cnt <= TICK_CYCLES + 4)
      else $error("hundredths did not advance in time");
   drive_xfer_a: assert property ($rose(serial_bit_line_oe_o) |-> mem_inhibit_o)
      else $error("line driven outside transfer");
   drive_read_a: assert property ($rose(serial_bit_line_oe_o) |-> $past(!ce_pin_n_i && !oe_pin_n_i, 3))
      else $error("line driven without read strobes");
   drive_hold_a: assert property (serial_bit_line_oe_o && !ce_pin_n_i && !oe_pin_n_i && rst_pin_n_i |=> serial_bit_line_oe_o)
      else $error("drive dropped during read");
   drive_release_a: assert property (ce_release |-> ##[1:8] !serial_bit_line_oe_o)
      else $error("drive not released after strobe");
   bit_stable_a: assert property (driving_on |-> $stable(serial_bit_line_o))
      else $error("driven bit changed mid read");
   inhibit_rise_a: assert property ($rose(mem_inhibit_o) |-> $past(ce_pin_n_i, 2) && $past(we_pin_n_i, 2))
      else $error("transfer entered outside a finished write");
endmodule

bind wro_core wro_core_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk_i(clk_i), .nrst_i(nrst_i),
   .en_i(en_i), .ce_pin_n_i(ce_pin_n_i), .oe_pin_n_i(oe_pin_n_i), .we_pin_n_i(we_pin_n_i),
   .rst_pin_n_i(rst_pin_n_i), .serial_bit_line_i(serial_bit_line_i),
   .serial_bit_line_o(serial_bit_line_o), .serial_bit_line_oe_o(serial_bit_line_oe_o),
   .mem_inhibit_o(mem_inhibit_o), .osc_running_o(osc_running_o), .hundredths_o(hundredths_o));
`default_nettype wire

// *** testbench/wro_host.sv ***
// host model: sram-style strobes on the watch pins, one bit per cycle on line 0
// assumes the clock runs throughout; the reset pin idles high as its pull-up would
`timescale 1ns/1ps
`default_nettype none
module wro_host (
   // clock
   input wire logic clk_i,
   // pins toward the core
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic rst_n_o,
   output logic line_o,
   input wire logic core_bit_i,
   input wire logic core_oe_i
);
   logic drv;
   logic dat;
   logic junk = 1'b0;
   // no pull on the data line: a released line must not look like the last bit
   always @(posedge clk_i) junk <= ~junk;
   assign line_o = core_oe_i ? core_bit_i : (drv ? dat : junk);
   initial {ce_n_o, oe_n_o, we_n_o, rst_n_o, drv, dat} = 6'b111100;
   // 12 clocks low, 12 high: well above the core's minimum spacing
   task automatic cycle(input logic wr, input logic d, output logic q);
      @(posedge clk_i);
      #1;
      {ce_n_o, we_n_o, oe_n_o, drv, dat} = {1'b0, !wr, wr, wr, d};
      repeat (12) @(posedge clk_i);
      q = line_o;
      #1;
      {ce_n_o, oe_n_o, we_n_o, drv} = 4'b1110;
      repeat (11) @(posedge clk_i);
   endtask
   // read, then n pattern bits low bit first; bad flips the last one
   task automatic open_watch(input int n, input logic bad);
      logic q;
      cycle(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) cycle(1'b1, wro_pkg::MATCH_PATTERN[i] ^ (bad && i == n - 1), q);
   endtask
   // 64 cycles, register 0 bit 0 first; unused bits go out as given
   task automatic xfer(input logic wr, input logic [63:0] wd, output logic [63:0] rd);
      for (int i = 0; i < 64; i++) cycle(wr, wd[i], rd[i]);
   endtask
   task automatic pulse_rst();
      @(posedge clk_i);
      #1;
      rst_n_o = 1'b0;
      repeat (20) @(posedge clk_i);
      #1;
      rst_n_o = 1'b1;
      repeat (10) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// *** testbench/wro_core_tb_top.sv ***
// bench for the serial watch control: match, transfer, reset pin and oscillator bits
// assumes the host model drives the pins and the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module wro_core_tb_top;
   localparam int TICK = 1000;
   // unused bits set to 1, day 1 with both control bits cleared
   localparam logic [63:0] W = 64'h00E1_C1C9_4080_8000;
   localparam logic [63:0] WM = W & wro_pkg::VALID_MASK;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ce_n, oe_n, we_n, rst_n, line, bit_o, bit_oe, inhibit, osc_on, q;
   logic [7:0] hund;
   logic [63:0] rd;
   int error_cnt = 0;
   int n_checks = 0;
   wro_core #(.TICK_CYCLES(TICK)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1),
      .ce_pin_n_i(ce_n), .oe_pin_n_i(oe_n), .we_pin_n_i(we_n), .rst_pin_n_i(rst_n),
      .serial_bit_line_i(line), .serial_bit_line_o(bit_o), .serial_bit_line_oe_o(bit_oe),
      .mem_inhibit_o(inhibit), .osc_running_o(osc_on), .hundredths_o(hund));
   wro_host i_host (.clk_i(clk_i), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .rst_n_o(rst_n),
      .line_o(line), .core_bit_i(bit_o), .core_oe_i(bit_oe));
   initial forever #4 clk_i = ~clk_i;
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic t_reset_state();
      check("inhibit", 64'(inhibit), 64'h0);
      check("osc_on", 64'(osc_on), 64'h0);
      repeat (2500) @(posedge clk_i);
      check("hund_stopped", 64'(hund), 64'h0);
   endtask
   task automatic t_match_read();
      i_host.open_watch(64, 1'b1);
      check("miss", 64'(inhibit), 64'h0);
      i_host.open_watch(20, 1'b0);
      i_host.open_watch(64, 1'b0);
      check("restart", 64'(inhibit), 64'h1);
      i_host.pulse_rst();
      check("rst_ignored", 64'(inhibit), 64'h1);
      i_host.xfer(1'b0, 64'h0, rd);
      check("regs_reset", rd, wro_pkg::REGS_RESET & wro_pkg::VALID_MASK);
      check("xfer_end", 64'(inhibit), 64'h0);
   endtask
   task automatic t_write();
      i_host.open_watch(64, 1'b0);
      i_host.xfer(1'b1, W, rd);
      check("osc_on", 64'(osc_on), 64'h1);
      repeat (2500) @(posedge clk_i);
      check("hund_runs", 64'(hund != 8'h00), 64'h1);
      i_host.open_watch(64, 1'b0);
      i_host.xfer(1'b0, 64'h0, rd);
      check("regs_back", 64'(rd[63:8]), 64'(WM[63:8]));
   endtask
   // reads only: an aborted write transfer would leave the expected image ambiguous
   task automatic t_abort();
      i_host.open_watch(64, 1'b0);
      for (int i = 0; i < 10; i++) i_host.cycle(1'b0, 1'b0, q);
      i_host.pulse_rst();
      check("aborted", 64'(inhibit), 64'h0);
      for (int i = 0; i < 5; i++) i_host.cycle(1'b0, 1'b0, q);
      check("to_memory", 64'(inhibit | bit_oe), 64'h0);
      i_host.open_watch(64, 1'b0);
      i_host.xfer(1'b0, 64'h0, rd);
      check("regs_kept", 64'(rd[63:8]), 64'(WM[63:8]));
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      t_reset_state();
      t_match_read();
      t_write();
      t_abort();
      summarize();
   end
endmodule
`default_nettype wire
